// ### verilog/sleep_regs_pkg.sv
/*
  Constants and carrier types for the radio sleep timer register group.
  Assumes a 32-bit APB slave at 20 MHz and one slow oscillator pin.
*/
// Operation
// - The 10-bit fine tick snapshot is read-only and refreshes on each sample trigger write.
// - The low 32 node address bits are read-write and reset to zero.
// - The high node address word holds 16 address bits and the address kind flag at bit 16.
// - One register holds the exchange table start in 31:16 and receive list start in 14:0.
// - External wake requests are ignored while the external wake block bit is one.
// - Read-only bit 15 shows whether the core sits in deep sleep on the slow clock.
// - Writing one to the software wake trigger wakes a sleeping core and self-clears.
// - Writing one to the correction go bit after a wake restarts the time counters.
// - The sleep request bit starts deep sleep and clears on the status falling edge.
// - Deep sleep lasts one slow clock cycle more than the programmed number.
// - The measured sleep count clears at sleep start and counts every slow cycle while the core is asleep or waking.
// - After an external wake the wake interrupt drops after the programmed delay.
// - The wake interrupt rises at the raise lead and falls at the clear lead before expiry.
package sleep_regs_pkg;
  localparam logic [31:0] OFF_FINE   = 32'h4000_0020;
  localparam logic [31:0] OFF_ADDR_L = 32'h4000_0024;
  localparam logic [31:0] OFF_ADDR_H = 32'h4000_0028;
  localparam logic [31:0] OFF_PTRS   = 32'h4000_002C;
  localparam logic [31:0] OFF_CTRL   = 32'h4000_0030;
  localparam logic [31:0] OFF_TARGET = 32'h4000_0034;
  localparam logic [31:0] OFF_MEAS   = 32'h4000_0038;
  localparam logic [31:0] OFF_TIMING = 32'h4000_003C;
  localparam logic [31:0] OFF_SAMPLE = 32'h4000_0070;
  localparam logic [31:0] OFF_STATUS = 32'h4000_0074;
  localparam logic [31:0] OFF_MASK   = 32'h4000_0078;
  localparam logic [31:0] REG_RESET  = 32'h0000_0000;
  localparam int KIND_BIT   = 16;
  localparam int ET_LSB     = 16;
  localparam int BLOCK_BIT  = 31;
  localparam int STAT_BIT   = 15;
  localparam int SOFT_BIT   = 4;
  localparam int CORR_BIT   = 3;
  localparam int SLEEP_BIT  = 2;
  localparam int EXT_LSB    = 21;
  localparam int RAISE_LSB  = 10;
  localparam int SAMPLE_BIT = 0;
  localparam int EV_WAKE    = 0;
  localparam int EV_SLEEP   = 1;
  localparam int NUM_EV     = 2;
  localparam logic [1:0] IRQ_EN_ON = 2'h3;

  typedef enum logic [1:0] {
    ST_AWAKE  = 2'h0,
    ST_ASLEEP = 2'h1,
    ST_WAKING = 2'h3
  } sleep_state_t;

  typedef struct packed {
    logic        kind;
    logic [15:0] high;
    logic [31:0] low;
  } node_addr_t;

  typedef struct packed {
    logic [15:0] exchange_table_start;
    logic [14:0] receive_list_start;
  } list_ptrs_t;
endpackage : sleep_regs_pkg

// ### verilog/radio_sleep_timer_registers.sv
/*
  Register group for the radio core: fine tick snapshot, node address,
  list pointers and the deep sleep sequencer with its wake interrupt.
  Assumes an APB master on clk_i; the slow oscillator and the external
  wake request are asynchronous pins; fine_tick_i comes from clk_i logic.
*/
`timescale 1ns/10ps
`default_nettype none
module radio_sleep_timer_registers
  import sleep_regs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output var  logic [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        slow_clk_i,
  input  wire logic        ext_wake_i,
  input  wire logic [9:0]  fine_tick_i,
  output var  node_addr_t  node_addr_o,
  output var  list_ptrs_t  list_ptrs_o,
  output var  logic        deep_sleep_o,
  output var  logic        slow_clock_wake_irq_o,
  output var  logic        post_wake_correction_go_o,
  output logic             irq_o
);

  // Register index decode, shared by the read mux and the write strobes.
  function automatic logic [3:0] reg_index(input logic [31:0] a);
    case (a)
      OFF_FINE:   reg_index = 4'h0;
      OFF_ADDR_L: reg_index = 4'h1;
      OFF_ADDR_H: reg_index = 4'h2;
      OFF_PTRS:   reg_index = 4'h3;
      OFF_CTRL:   reg_index = 4'h4;
      OFF_TARGET: reg_index = 4'h5;
      OFF_MEAS:   reg_index = 4'h6;
      OFF_TIMING: reg_index = 4'h7;
      OFF_SAMPLE: reg_index = 4'h8;
      OFF_STATUS: reg_index = 4'h9;
      OFF_MASK:   reg_index = 4'hA;
      default:    reg_index = 4'hF;
    endcase
  endfunction : reg_index

  logic               slow_meta;
  logic               slow_sync;
  logic               slow_prev;
  logic               ext_meta;
  logic               ext_sync;
  logic               tick;
  logic               setup;
  logic               access;
  logic               wr;
  logic [3:0]         idx;
  logic [9:0]         fine_snap;
  logic               ext_block;
  logic               soft_wake;
  logic               corr_pend;
  logic               sleep_on;
  logic [1:0]         irq_en;
  logic [31:0]        target;
  logic [31:0]        measured;
  logic [31:0]        remaining;
  logic [31:0]        timing;
  logic [10:0]        ext_delay;
  logic [10:0]        dly_cnt;
  sleep_state_t       state;
  sleep_state_t       next_state;
  logic               sleeping;
  logic               sleeping_q;
  logic               woke;
  logic               ext_req;
  logic [NUM_EV-1:0]  ev_status;
  logic [NUM_EV-1:0]  ev_mask;
  logic [NUM_EV-1:0]  ev_set;
  logic [31:0]        rd_mux;

  // Two flops on each pin and a third on the slow pin; the first flop is never looked at.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slow_meta <= 1'b0;
      slow_sync <= 1'b0;
      slow_prev <= 1'b0;
      ext_meta  <= 1'b0;
      ext_sync  <= 1'b0;
    end else begin
      slow_meta <= slow_clk_i;
      slow_sync <= slow_meta;
      slow_prev <= slow_sync;
      ext_meta  <= ext_wake_i;
      ext_sync  <= ext_meta;
    end
  end

  // One slow cycle is one rising edge seen after synchronisation.
  assign tick      = slow_sync & ~slow_prev;
  assign setup     = psel_i & ~penable_i;
  assign access    = psel_i & penable_i;
  assign wr        = access & pwrite_i;
  assign idx       = reg_index(paddr_i);
  assign ext_delay = timing[31:EXT_LSB];
  assign sleeping  = (state != ST_AWAKE);
  assign ext_req   = ext_sync & ~ext_block;

  // Zero wait states keep the bus simple; read data is latched in setup.
  assign pready_o  = access;
  assign pslverr_o = access & (idx == 4'hF);

  // Read mux; write-one-only control bits read back as zero, except bit 4, which shows the one-cycle software wake flop.
  always_comb begin
    case (idx)
      4'h0: rd_mux = {22'h0, fine_snap};
      4'h1: rd_mux = node_addr_o.low;
      4'h2: rd_mux = {15'h0, node_addr_o.kind, node_addr_o.high};
      4'h3: rd_mux = {list_ptrs_o.exchange_table_start, 1'b0,
                      list_ptrs_o.receive_list_start};
      4'h4: rd_mux = {ext_block, 15'h0, sleeping, 10'h0, soft_wake,
                      2'h0, irq_en};
      4'h5: rd_mux = target;
      4'h6: rd_mux = measured;
      4'h7: rd_mux = timing;
      4'h9: rd_mux = {30'h0, ev_status};
      4'hA: rd_mux = {30'h0, ev_mask};
      default: rd_mux = REG_RESET;
    endcase
  end

  // Read data is a flop loaded during the setup cycle.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prdata_o <= REG_RESET;
    end else if (setup && !pwrite_i) begin
      prdata_o <= rd_mux;
    end
  end

  // Snapshot of the fine counter, refreshed by the sample trigger.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fine_snap <= 10'h000;
    end else if (wr && idx == 4'h8 && pwdata_i[SAMPLE_BIT]) begin
      fine_snap <= fine_tick_i;
    end
  end

  // Plain read-write configuration words.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      node_addr_o <= '0;
      list_ptrs_o <= '0;
      target      <= REG_RESET;
      timing      <= REG_RESET;
      ev_mask     <= '0;
      ext_block   <= 1'b0;
      irq_en      <= 2'h0;
    end else if (wr) begin
      case (idx)
        4'h1: node_addr_o.low <= pwdata_i;
        4'h2: begin
          node_addr_o.high <= pwdata_i[15:0];
          node_addr_o.kind <= pwdata_i[KIND_BIT];
        end
        4'h3: begin
          list_ptrs_o.exchange_table_start <= pwdata_i[31:ET_LSB];
          list_ptrs_o.receive_list_start   <= pwdata_i[14:0];
        end
        4'h4: begin
          ext_block <= pwdata_i[BLOCK_BIT];
          irq_en    <= pwdata_i[1:0];
        end
        4'h5: target  <= pwdata_i;
        4'h7: timing  <= pwdata_i;
        4'hA: ev_mask <= pwdata_i[NUM_EV-1:0];
        default: ;
      endcase
    end
  end

  // Sleep request; a write in the same cycle as the fall wins.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sleep_on <= 1'b0;
    end else if (wr && idx == 4'h4 && pwdata_i[SLEEP_BIT]) begin
      sleep_on <= 1'b1;
    end else if (sleeping_q && !sleeping) begin
      sleep_on <= 1'b0;
    end
  end

  // Software wake lives one cycle: acted on if asleep, else dropped.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      soft_wake <= 1'b0;
    end else begin
      soft_wake <= wr && idx == 4'h4 && pwdata_i[SOFT_BIT];
    end
  end

  // Correction only counts after a wake, so a stray write is harmless.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      corr_pend                 <= 1'b0;
      woke                      <= 1'b0;
      post_wake_correction_go_o <= 1'b0;
    end else begin
      corr_pend <= wr && idx == 4'h4 && pwdata_i[CORR_BIT];
      post_wake_correction_go_o <= corr_pend && woke;
      if (sleeping_q && !sleeping) begin
        woke <= 1'b1;
      end else if (corr_pend) begin
        woke <= 1'b0;
      end
    end
  end

  // Sequencer next state.
  always_comb begin
    next_state = state;
    case (state)
      ST_AWAKE: begin
        if (tick && sleep_on && !sleeping_q) begin
          next_state = ST_ASLEEP;
        end
      end
      ST_ASLEEP: begin
        if (soft_wake) begin
          next_state = ST_AWAKE;
        end else if (ext_req) begin
          next_state = ST_WAKING;
        end else if (tick && remaining == 32'h0) begin
          next_state = ST_AWAKE;
        end
      end
      ST_WAKING: begin
        if (soft_wake || (tick && dly_cnt >= ext_delay)) begin
          next_state = ST_AWAKE;
        end
      end
      default: next_state = ST_AWAKE;
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state      <= ST_AWAKE;
      sleeping_q <= 1'b0;
    end else begin
      state      <= next_state;
      sleeping_q <= sleeping;
    end
  end

  // The status bit mirrors the clock mux select toward the core.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      deep_sleep_o <= 1'b0;
    end else begin
      deep_sleep_o <= (next_state != ST_AWAKE);
    end
  end

  // Countdown and measured duration, both stepped by slow ticks.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      remaining <= REG_RESET;
      measured  <= REG_RESET;
    end else if (state == ST_AWAKE && next_state == ST_ASLEEP) begin
      remaining <= target;
      measured  <= REG_RESET;
    end else if (sleeping && tick) begin
      measured <= measured + 32'h1;
      if (remaining != 32'h0) begin
        remaining <= remaining - 32'h1;
      end
    end
  end

  // Delay counter for the external wake interrupt release.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dly_cnt <= 11'h000;
    end else if (state != ST_WAKING) begin
      dly_cnt <= 11'h000;
    end else if (tick) begin
      dly_cnt <= dly_cnt + 11'h001;
    end
  end

  // Wake interrupt: raised before expiry or on external wake, released
  // at the clear lead, after the delay, or when the core is awake.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      slow_clock_wake_irq_o <= 1'b0;
    end else if (next_state == ST_AWAKE) begin
      slow_clock_wake_irq_o <= 1'b0;
    end else if (state == ST_ASLEEP && next_state == ST_WAKING) begin
      slow_clock_wake_irq_o <= (irq_en == IRQ_EN_ON);
    end else if (state == ST_ASLEEP && tick && irq_en == IRQ_EN_ON) begin
      if (remaining == {22'h0, timing[9:0]}) begin
        slow_clock_wake_irq_o <= 1'b0;
      end else if (remaining == {21'h0, timing[20:RAISE_LSB]}) begin
        slow_clock_wake_irq_o <= 1'b1;
      end
    end
  end

  // Sticky events; hardware set beats a same-cycle write-one clear.
  assign ev_set[EV_WAKE]  = sleeping_q && !sleeping;
  assign ev_set[EV_SLEEP] = !sleeping_q && sleeping;

  generate
    for (genvar i = 0; i < NUM_EV; i++) begin : g_ev
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
          ev_status[i] <= 1'b0;
        end else if (ev_set[i]) begin
          ev_status[i] <= 1'b1;
        end else if (wr && idx == 4'h9 && pwdata_i[i]) begin
          ev_status[i] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq_o = |(ev_status & ev_mask);

  a_snap_update: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr && idx == 4'h8 && pwdata_i[SAMPLE_BIT]
    |=> fine_snap == $past(fine_tick_i))
    else $error("fine snapshot not refreshed");

  a_addr_low: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr && idx == 4'h1 |=> node_addr_o.low == $past(pwdata_i))
    else $error("address low not stored");

  a_addr_kind: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr && idx == 4'h2
    |=> node_addr_o.kind == $past(pwdata_i[KIND_BIT]))
    else $error("address kind not stored");

  a_ptr_split: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr && idx == 4'h3 |=> list_ptrs_o.receive_list_start
    == $past(pwdata_i[14:0]))
    else $error("receive list start not stored");

  a_ext_blocked: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state == ST_ASLEEP && ext_block |=> state != ST_WAKING)
    else $error("blocked external wake acted");

  a_stat_read: assert property (@(posedge clk_i) disable iff (!resetn_i)
    setup && !pwrite_i && idx == 4'h4
    |=> prdata_o[STAT_BIT] == $past(sleeping))
    else $error("sleep status read wrong");

  a_soft_wake: assert property (@(posedge clk_i) disable iff (!resetn_i)
    soft_wake && sleeping |=> state == ST_AWAKE && !soft_wake)
    else $error("software wake ignored");

  a_corr_pulse: assert property (@(posedge clk_i) disable iff (!resetn_i)
    post_wake_correction_go_o |=> !post_wake_correction_go_o && !woke)
    else $error("correction pulse stuck");

  a_sleep_clear: assert property (@(posedge clk_i) disable iff (!resetn_i)
    sleeping_q && !sleeping && !(wr && idx == 4'h4) |=> !sleep_on)
    else $error("sleep request not cleared");

  a_timer_wake: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state == ST_ASLEEP && tick && remaining == 32'h0 && !ext_req
    |=> state == ST_AWAKE ##1 !deep_sleep_o)
    else $error("timer expiry did not wake");

  a_measure: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state == ST_ASLEEP && tick && next_state == ST_ASLEEP
    |=> measured == $past(measured) + 32'h1)
    else $error("measured count did not step");

  a_ext_release: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state == ST_WAKING && tick && dly_cnt >= ext_delay
    |=> !slow_clock_wake_irq_o && state == ST_AWAKE)
    else $error("external wake irq not released");

  a_irq_raise: assert property (@(posedge clk_i) disable iff (!resetn_i)
    state == ST_ASLEEP && next_state == ST_ASLEEP && tick
    && irq_en == IRQ_EN_ON && remaining != {22'h0, timing[9:0]}
    && remaining == {21'h0, timing[20:RAISE_LSB]}
    |=> slow_clock_wake_irq_o)
    else $error("wake irq not raised at lead");

endmodule : radio_sleep_timer_registers
`default_nettype wire

// ### tb/tb_radio_sleep_timer_registers.sv
/*
  Self-checking bench for the radio sleep timer register group.
  Assumes the zero-wait APB slave and slow-tick behaviour of the block.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_radio_sleep_timer_registers;
  import sleep_regs_pkg::*;
  logic        clk_i, resetn_i, psel, penable, pwrite, slow, ext;
  logic [31:0] paddr, pwdata, prdata, q, d;
  logic        pready, pslverr, err, deep, wirq, go, irq, seen;
  logic [9:0]  tick_v;
  node_addr_t  na;
  list_ptrs_t  lp;
  int          num_errors, total_checks;
  logic [31:0] rw_addr [5] = '{OFF_ADDR_L, OFF_ADDR_H, OFF_PTRS,
                               OFF_TARGET, OFF_TIMING};
  logic [31:0] all_addr [11] = '{OFF_FINE, OFF_ADDR_L, OFF_ADDR_H,
    OFF_PTRS, OFF_CTRL, OFF_TARGET, OFF_MEAS, OFF_TIMING, OFF_SAMPLE,
    OFF_STATUS, OFF_MASK};
  logic [31:0] shadow [5];

  radio_sleep_timer_registers i_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .slow_clk_i(slow), .ext_wake_i(ext),
    .fine_tick_i(tick_v), .node_addr_o(na), .list_ptrs_o(lp),
    .deep_sleep_o(deep), .slow_clock_wake_irq_o(wirq),
    .post_wake_correction_go_o(go), .irq_o(irq));

  // Free-running system clock, 50 ns period.
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  // Writable bits of each read-write register.
  function automatic logic [31:0] wmask(input logic [31:0] a);
    case (a)
      OFF_ADDR_H: return 32'h0001_FFFF;
      OFF_PTRS:   return 32'hFFFF_7FFF;
      default:    return 32'hFFFF_FFFF;
    endcase
  endfunction : wmask

  task automatic check(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : check

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  // One APB transfer; request held until pready is seen at an edge.
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] wd);
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees pready.
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [31:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  // Slow oscillator pulses, each long enough to pass the synchroniser.
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk_i) slow <= 1'b1;
      repeat (4) @(posedge clk_i);
      slow <= 1'b0;
      repeat (4) @(posedge clk_i);
    end
  endtask : tick

  // Watchdog sized well above the expected run length.
  initial begin
    repeat (40000) @(posedge clk_i);
    num_errors++;
    test_done();
  end

  // Main sequence.
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    slow = 0; ext = 0; tick_v = 0; resetn_i = 0;
    num_errors = 0; total_checks = 0;
    void'($urandom(32'h7fa1));
    repeat (10) @(posedge clk_i);
    resetn_i <= 1'b1;
    foreach (all_addr[i]) begin
      rd(all_addr[i]);
      check(q, REG_RESET);
    end
    // Random read-write traffic with a corner pattern first.
    for (int k = 0; k < 4; k++)
      foreach (rw_addr[i]) begin
        d = (k == 0) ? 32'hFFFF_FFFF : $urandom;
        apb(1'b1, rw_addr[i], d);
        shadow[i] = d & wmask(rw_addr[i]);
        rd(rw_addr[i]);
        check(q, shadow[i]);
      end
    check(na.low, shadow[0]);
    check({15'h0000, na.kind, na.high}, shadow[1]);
    check({lp.exchange_table_start, 1'b0, lp.receive_list_start},
          shadow[2]);
    // Read-only places ignore writes; snapshot follows the trigger only.
    apb(1'b1, OFF_MEAS, 32'h1234_5678);
    rd(OFF_MEAS);
    check(q, REG_RESET);
    tick_v <= 10'($urandom);
    apb(1'b1, OFF_SAMPLE, 32'h0000_0001);
    d = {22'h0, tick_v};
    tick_v <= ~tick_v;
    apb(1'b1, OFF_FINE, 32'hFFFF_FFFF);
    rd(OFF_FINE);
    check(q, d);
    apb(1'b1, 32'h4000_0060, 32'hFFFF_FFFF);
    check(32'(err), 32'h0000_0001);
    rd(32'h4000_0060);
    check(32'(err), 32'h0000_0001);
    check(q, REG_RESET);
    // Timed sleep: target 4 means five slow cycles asleep.
    apb(1'b1, OFF_TARGET, 32'h0000_0004);
    apb(1'b1, OFF_TIMING, 32'h0040_0C01);
    apb(1'b1, OFF_MASK, 32'h0000_0003);
    apb(1'b1, OFF_CTRL, 32'h0000_0007);
    tick(1);
    check(32'(deep), 32'h0000_0001);
    rd(OFF_CTRL);
    check(q, 32'h0000_8003);
    check(32'(irq), 32'h0000_0001);
    seen = 0;
    for (int k = 1; k <= 5; k++) begin
      tick(1);
      seen |= wirq;
      check(32'(deep), 32'(k < 5));
    end
    check(32'({seen, wirq}), 32'h0000_0002);
    rd(OFF_MEAS);
    check(q, 32'h0000_0005);
    rd(OFF_CTRL);
    check(q, 32'h0000_0003);
    rd(OFF_STATUS);
    check(q, 32'h0000_0003);
    // The mask and status flops load at the access edge, so look later.
    apb(1'b1, OFF_MASK, 32'h0000_0000);
    @(negedge clk_i);
    check(32'(irq), 32'h0000_0000);
    apb(1'b1, OFF_MASK, 32'h0000_0002);
    @(negedge clk_i);
    check(32'(irq), 32'h0000_0001);
    apb(1'b1, OFF_STATUS, 32'h0000_0002);
    @(negedge clk_i);
    check(32'(irq), 32'h0000_0000);
    rd(OFF_STATUS);
    check(q, 32'h0000_0001);
    // Correction pulse only once per wake.
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, OFF_CTRL, 32'h0000_000B);
      seen = 0;
      repeat (6) @(posedge clk_i) seen |= go;
      check(32'(seen), 32'(k == 0));
    end
    // Software wake from a long sleep.
    apb(1'b1, OFF_TARGET, 32'h0000_03E8);
    apb(1'b1, OFF_CTRL, 32'h0000_0007);
    tick(1);
    check(32'(deep), 32'h0000_0001);
    apb(1'b1, OFF_CTRL, 32'h0000_0013);
    repeat (6) @(posedge clk_i);
    check(32'(deep), 32'h0000_0000);
    rd(OFF_CTRL);
    check(q, 32'h0000_0003);
    // External wake: blocked first, then let through.
    apb(1'b1, OFF_CTRL, 32'h8000_0007);
    tick(1);
    ext <= 1'b1;
    tick(3);
    check(32'(deep), 32'h0000_0001);
    apb(1'b1, OFF_CTRL, 32'h0000_0007);
    repeat (6) @(posedge clk_i);
    check(32'({deep, wirq}), 32'h0000_0003);
    ext <= 1'b0;
    tick(3);
    check(32'({deep, wirq}), 32'h0000_0000);
    test_done();
  end
endmodule : tb_radio_sleep_timer_registers
`default_nettype wire
